/* File: hw/pnc_top.sv */
// Purpose: Negotiation control, crossover, straps, isolate, indicators
// Assumes: Management frames deframed to single-cycle strobes
// Notes: Long timers are parameters so simulation can shorten them
//
// Summary of operation
// - Parallel detect sets partner ability bit 5 or 7 per technology.
// - Parallel detect loads partner selector field with 00001.
// - Parallel detect: partner-able bit zero, complete bit one.
// - Both links good in parallel detect sets fault bit.
// - Writing bit 9 with bit 12 set in basic mode control restarts negotiation.
// - Loss of negotiated link resumes negotiation.
// - Renegotiation silences output for break timer, then sends bursts.
// - Negotiation completes within about three seconds or retries.
// - Auto crossover on by default, strap/register set, random timing.
// - Force crossover bit swaps pairs regardless of other modes.
// - Station address latched from straps into control bits 4:0.
// - Strapped address zero isolates; written zero does not.
// - Station address defaults to 00001.
// - Bit 10 of basic mode control enters isolate mode.
// - Isolate ignores transmit inputs, floats MII outputs.
// - Isolate keeps idles/pulses and negotiation, no packet data.
// - Indicator mode from control bits 6:5 or strap.
// - Link indicator on for link, blinks for activity in modes 2/3.
// - 10 Mb/s link after seven pulses or one packet; loss timer.
// - Speed indicator shows 100 Mb/s in every mode.
// - Act/col indicator shows activity, collision or duplex by mode.
// - Indicator polarity follows strap level latched at reset.
// - Low strap gives active high, high strap active low.

module pnc_top
    import pnc_pkg::*;
#(
    parameter int unsigned BREAK_CYCLES = BREAK_LINK_CYC,
    parameter int unsigned AN_CYCLES = AN_DONE_CYC,
    parameter int unsigned LOSS_CYCLES = LINK_LOSS_CYC,
    parameter int unsigned XOVER_CYCLES = XOVER_SLOT_CYC,
    parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Async reset, active low
    input wire logic clk_en, // Freeze all state when low
    input wire pnc_mgmt_req_type mgmt_req, // Management access
    output logic [15:0] mgmt_rdata, // Read data
    output logic mgmt_rvalid, // Read data valid pulse
    input wire pnc_strap_type straps, // Strap pin levels
    input wire logic signal_detect, // 100 Mb/s signal present
    input wire logic nlp_pulse, // Normal link pulse seen
    input wire logic packet_ok, // Valid 10 Mb/s packet seen
    input wire logic flp_burst_seen, // Partner sends bursts
    input wire logic flp_page_valid, // Partner base page taken
    input wire logic [15:0] flp_page, // Partner base page
    input wire logic tx_en_in, // Transmit enable from MAC
    input wire logic tx_active, // Transmit activity
    input wire logic rx_active, // Receive activity
    input wire logic col_in, // Collision signal
    output logic tx_en_gated, // Transmit enable to data path
    output logic mii_out_oe_b, // MII outputs enable, low drives
    output logic media_data_en, // Packet data allowed on media
    output logic media_pulse_en, // Idles or link pulses allowed
    output logic flp_send, // Send negotiation bursts
    output logic crossover, // Media pairs swapped
    output logic link_up, // Link good
    output logic speed_100, // 100 Mb/s operation
    output logic full_duplex, // Full duplex operation
    output logic link_indicator, // Link indicator pin
    output logic speed_indicator, // Speed indicator pin
    output logic activity_collision_indicator // Act/col pin
);

    // ==========================================================
    // Helpers
    function automatic logic [3:0] adv_from_strap(input logic a1,
                                                  input logic a0);
        case ({a1, a0})
            2'h0: adv_from_strap = 4'h3;
            2'h1: adv_from_strap = 4'hc;
            2'h2: adv_from_strap = 4'h5;
            default: adv_from_strap = 4'hf;
        endcase
    endfunction

    pnc_state_type s, n;
    logic link_good;
    logic an_go;
    logic isolate;
    logic restart_req;
    logic [3:0] common;
    logic collision;

    assign link_good = signal_detect | s.link10;
    assign an_go = s.bmc[BMC_NEGOTIATION_STRAP] & s.an_armed;
    assign isolate = s.bmc[BMC_ISOLATE] | s.strap_iso;
    assign restart_req = mgmt_req.wr & (mgmt_req.addr == REG_BMC)
                         & mgmt_req.wdata[BMC_RESTART] & s.strap_done;
    assign common = s.adv & {s.lpa[LPA_100FD], s.lpa[LPA_100HD],
                             s.lpa[LPA_10FD], s.lpa[LPA_10HD]};

    // ==========================================================
    // Next state
    always_comb begin
        n = s;
        n.rvalid = 1'b0;
        n.lfsr = s.lfsr[0] ? ((s.lfsr >> 1) ^ LFSR_TAPS) : (s.lfsr >> 1);
        if (!s.strap_done) begin
            n.strap_done = 1'b1;
            n.pctl[4:0] = straps.station_address_strap;
            n.strap_iso = (straps.station_address_strap == 5'h00);
            n.pctl[PCTL_CFG_LSB] = straps.indicator_config;
            n.pctl[PCTL_AUTO_X] = straps.mdix_en;
            n.pol = {straps.an0, straps.an1, straps.negotiation_strap};
            n.bmc[BMC_NEGOTIATION_STRAP] = straps.negotiation_strap;
            n.bmc[BMC_SPEED] = straps.an1;
            n.bmc[BMC_DUPLEX] = straps.an0;
            n.an_armed = straps.negotiation_strap;
            n.adv = straps.negotiation_strap ?
                    adv_from_strap(straps.an1, straps.an0) : 4'h0;
        end else if (mgmt_req.wr) begin
            case (mgmt_req.addr)
                REG_BMC: begin
                    n.bmc = mgmt_req.wdata & BMC_WMASK;
                    if (!mgmt_req.wdata[BMC_NEGOTIATION_STRAP]) begin
                        n.an_cleared = 1'b1;
                    end else if (s.an_cleared) begin
                        n.an_armed = 1'b1;
                        if (n.adv == 4'h0) begin
                            n.adv = 4'hf;
                        end
                    end
                end
                REG_PCTL: begin
                    n.pctl = {mgmt_req.wdata[15:14], 9'h000,
                              mgmt_req.wdata[4:0]};
                    n.pctl[6:5] = mgmt_req.wdata[6:5];
                end
                default: begin
                end
            endcase
        end else if (mgmt_req.rd) begin
            n.rvalid = 1'b1;
            case (mgmt_req.addr)
                REG_BMC: n.rdata = s.bmc;
                REG_BMS: begin
                    n.rdata = 16'h0000;
                    n.rdata[BMS_AN_ABLE] = 1'b1;
                    n.rdata[BMS_LINK] = link_good;
                    n.rdata[BMS_AN_DONE] = s.an_complete;
                end
                REG_LPA: n.rdata = s.lpa;
                REG_EXP: begin
                    n.rdata = 16'h0000;
                    n.rdata[EXP_LP_AN_ABLE] = s.lp_an_able;
                    n.rdata[EXP_PD_FAULT] = s.pd_fault;
                    // Read clears fault; a new fault below wins
                    n.pd_fault = 1'b0;
                end
                REG_PCTL: n.rdata = s.pctl;
                default: n.rdata = 16'h0000;
            endcase
        end

        if (packet_ok) begin
            n.link10 = 1'b1;
            n.loss_timer = 32'h0;
        end else if (nlp_pulse) begin
            n.loss_timer = 32'h0;
            if (s.nlp_cnt >= NLP_LINK_COUNT - 3'h1) begin
                n.link10 = 1'b1;
            end else begin
                n.nlp_cnt = s.nlp_cnt + 3'h1;
            end
        end else if (s.loss_timer >= LOSS_CYCLES - 1) begin
            n.link10 = 1'b0;
            n.nlp_cnt = 3'h0;
        end else begin
            n.loss_timer = s.loss_timer + 32'h1;
        end

        // Negotiation; runs on in isolate too
        // negotiation continues
        case (s.an_state)
            AN_OFF: begin
                if (an_go) begin
                    n.an_state = AN_BREAK;
                    n.timer = 32'h0;
                    n.an_complete = 1'b0;
                end
            end
            AN_BREAK: begin
                if (s.timer >= BREAK_CYCLES - 1) begin
                    n.an_state = AN_DETECT;
                    n.timer = 32'h0;
                end else begin
                    n.timer = s.timer + 32'h1;
                end
            end
            AN_DETECT: begin
                n.timer = s.timer + 32'h1;
                if (flp_page_valid) begin
                    n.lpa = flp_page;
                    n.lp_an_able = 1'b1;
                    n.an_complete = 1'b1;
                    n.an_state = AN_DONE;
                end else if (!flp_burst_seen && signal_detect
                             && s.link10) begin
                    n.pd_fault = 1'b1;
                end else if (!flp_burst_seen && link_good) begin
                    n.lpa = signal_detect ? LPA_PD_100 : LPA_PD_10;
                    n.lpa[4:0] = SELECTOR_8023;
                    n.lp_an_able = 1'b0;
                    n.an_complete = 1'b1;
                    n.an_state = AN_DONE;
                end else if (s.timer >= AN_CYCLES - 1) begin
                    n.an_state = AN_BREAK;
                    n.timer = 32'h0;
                end
            end
            AN_DONE: begin
                if (!link_good) begin
                    n.an_state = AN_DETECT;
                    n.an_complete = 1'b0;
                    n.timer = 32'h0;
                end
            end
            default: n.an_state = AN_OFF;
        endcase
        if (s.an_state == AN_DETECT && n.an_state == AN_DONE) begin
            n.res_100 = (|n.lpa[LPA_100FD:LPA_100HD])
                        & (n.lp_an_able ? (|common[3:2]) : 1'b1);
            n.res_fd = n.lp_an_able &
                       (n.res_100 ? common[3] : common[1]);
        end
        if (restart_req && n.bmc[BMC_NEGOTIATION_STRAP] && n.an_armed) begin
            n.an_state = AN_BREAK;
            n.timer = 32'h0;
            n.an_complete = 1'b0;
        end
        if (!(n.bmc[BMC_NEGOTIATION_STRAP] && n.an_armed)) begin
            n.an_state = AN_OFF;
            n.an_complete = 1'b0;
        end

        if (s.pctl[PCTL_FORCE_X]) begin
            n.xover = 1'b1;
            n.xtimer = 32'h0;
        end else if (s.pctl[PCTL_AUTO_X] && s.an_state != AN_OFF
                     && !link_good) begin
            if (s.xtimer >= XOVER_CYCLES - 1) begin
                n.xtimer = 32'h0;
                if (s.lfsr[0]) begin
                    n.xover = ~s.xover;
                end
            end else begin
                n.xtimer = s.xtimer + 32'h1;
            end
        end else if (!s.pctl[PCTL_AUTO_X]) begin
            n.xover = 1'b0;
            n.xtimer = 32'h0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.an_state <= AN_OFF;
            s.lfsr <= LFSR_SEED;
            s.pctl <= {11'h000, ADDR_RESET};
            s.bmc <= 16'h1000;
        end else if (clk_en) begin
            s <= n;
        end
    end

    // ==========================================================
    // Outputs
    assign mgmt_rdata = s.rdata;
    assign mgmt_rvalid = s.rvalid;
    assign link_up = link_good;
    assign crossover = s.xover;
    assign speed_100 = an_go ? s.res_100 : s.bmc[BMC_SPEED];
    assign full_duplex = an_go ? s.res_fd : s.bmc[BMC_DUPLEX];
    assign mii_out_oe_b = isolate | ~s.strap_done;
    assign media_data_en = ~isolate & link_good & s.strap_done
                           & (s.an_state == AN_DONE || s.an_state == AN_OFF);
    assign tx_en_gated = tx_en_in & media_data_en;
    assign media_pulse_en = s.strap_done & (s.an_state != AN_BREAK);
    assign flp_send = (s.an_state == AN_DETECT);
    assign collision = ~full_duplex & (speed_100 ? (tx_active & rx_active)
                                                 : col_in);

    pnc_indicator #(
        .BLINK_CYCLES(BLINK_CYCLES)
    ) u_ind (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .cfg(s.pctl[PCTL_CFG_LSB+1:PCTL_CFG_LSB]),
        .link(link_good),
        .speed_100(speed_100),
        .full_duplex(full_duplex),
        .activity(tx_active | rx_active),
        .collision(collision),
        .pol(s.pol),
        .link_indicator(link_indicator),
        .speed_indicator(speed_indicator),
        .activity_collision_indicator(activity_collision_indicator)
    );

endmodule

/* File: hw/pnc_pkg.sv */
// Purpose: Shared constants and types for the negotiation/config block
// Assumes: 125 MHz ref_clk, management transactions already deframed
// Notes: Register offsets are management register numbers

package pnc_pkg;

    // ==========================================================
    // Register map
    localparam logic [4:0] REG_BMC = 5'h00;
    localparam logic [4:0] REG_BMS = 5'h01;
    localparam logic [4:0] REG_LPA = 5'h05;
    localparam logic [4:0] REG_EXP = 5'h06;
    localparam logic [4:0] REG_PCTL = 5'h19;

    // ==========================================================
    // Field positions
    localparam int BMC_DUPLEX = 8;
    localparam int BMC_RESTART = 9;
    localparam int BMC_ISOLATE = 10;
    localparam int BMC_NEGOTIATION_STRAP = 12;
    localparam int BMC_SPEED = 13;
    localparam int BMS_LINK = 2;
    localparam int BMS_AN_ABLE = 3;
    localparam int BMS_AN_DONE = 5;
    localparam int EXP_LP_AN_ABLE = 0;
    localparam int EXP_PD_FAULT = 4;
    localparam int PCTL_AUTO_X = 15;
    localparam int PCTL_FORCE_X = 14;
    localparam int PCTL_CFG_LSB = 5;
    localparam int LPA_10HD = 5;
    localparam int LPA_10FD = 6;
    localparam int LPA_100HD = 7;
    localparam int LPA_100FD = 8;

    // ==========================================================
    // Reset and fixed values
    localparam logic [15:0] BMC_WMASK = 16'h3500;
    localparam logic [4:0] ADDR_RESET = 5'h01;
    localparam logic [4:0] SELECTOR_8023 = 5'h01;
    localparam logic [15:0] LPA_PD_100 = 16'h0081;
    localparam logic [15:0] LPA_PD_10 = 16'h0021;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
    localparam logic [2:0] NLP_LINK_COUNT = 3'h7;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned BREAK_LINK_MS = 1500;
    localparam int unsigned AN_DONE_MS = 3000;
    localparam int unsigned LINK_LOSS_MS = 50;
    localparam int unsigned XOVER_SLOT_MS = 60;
    localparam int unsigned BLINK_MS = 50;
    localparam int unsigned BREAK_LINK_CYC = BREAK_LINK_MS * CLK_KHZ;
    localparam int unsigned AN_DONE_CYC = AN_DONE_MS * CLK_KHZ;
    localparam int unsigned LINK_LOSS_CYC = LINK_LOSS_MS * CLK_KHZ;
    localparam int unsigned XOVER_SLOT_CYC = XOVER_SLOT_MS * CLK_KHZ;
    localparam int unsigned BLINK_CYC = BLINK_MS * CLK_KHZ;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        AN_OFF,
        AN_BREAK,
        AN_DETECT,
        AN_DONE
    } pnc_an_state_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pnc_mgmt_req_type;

    typedef struct packed {
        logic [4:0] station_address_strap;
        logic indicator_config;
        logic negotiation_strap;
        logic an1;
        logic an0;
        logic mdix_en;
    } pnc_strap_type;

    typedef struct packed {
        pnc_an_state_type an_state;
        logic [31:0] timer;
        logic [15:0] bmc;
        logic [15:0] pctl;
        logic [15:0] lpa;
        logic [3:0] adv;
        logic an_complete;
        logic lp_an_able;
        logic pd_fault;
        logic an_armed;
        logic an_cleared;
        logic strap_done;
        logic strap_iso;
        logic [2:0] pol;
        logic [2:0] nlp_cnt;
        logic link10;
        logic [31:0] loss_timer;
        logic res_100;
        logic res_fd;
        logic xover;
        logic [31:0] xtimer;
        logic [15:0] lfsr;
        logic [15:0] rdata;
        logic rvalid;
    } pnc_state_type;

    typedef struct packed {
        logic [31:0] blink_cnt;
        logic blink_ph;
        logic [2:0] led;
    } pnc_ind_state_type;

endpackage

/* File: hw/pnc_indicator.sv */
// Purpose: Three indicator outputs, link and act/col multi-mode, with strap polarity
// Assumes: Inputs synchronous to ref_clk
// Notes: Outputs registered; polarity fixed at strap time

module pnc_indicator
    import pnc_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Async reset
    input wire logic clk_en, // Freeze when low
    input wire logic [1:0] cfg, // Indicator config bits
    input wire logic link, // Good link
    input wire logic speed_100, // 100 Mb/s operation
    input wire logic full_duplex, // Full duplex operation
    input wire logic activity, // Tx or rx activity
    input wire logic collision, // Collision status
    input wire logic [2:0] pol, // Strap levels link/speed/act
    output logic link_indicator, // Link output
    output logic speed_indicator, // Speed output
    output logic activity_collision_indicator // Act/col output
);

    // ==========================================================
    // Mode decode
    function automatic logic [1:0] ind_mode(input logic [1:0] c);
        if (c[0]) begin
            ind_mode = 2'h1;
        end else if (c[1]) begin
            ind_mode = 2'h3;
        end else begin
            ind_mode = 2'h2;
        end
    endfunction

    pnc_ind_state_type s, n;
    logic [1:0] mode;
    logic [2:0] on;

    always_comb begin
        n = s;
        mode = ind_mode(cfg);
        if (activity) begin
            if (s.blink_cnt >= BLINK_CYCLES - 1) begin
                n.blink_cnt = 32'h0;
                n.blink_ph = ~s.blink_ph;
            end else begin
                n.blink_cnt = s.blink_cnt + 32'h1;
            end
        end else begin
            n.blink_cnt = 32'h0;
            n.blink_ph = 1'b0;
        end
        if (mode == 2'h1) begin
            on[2] = link;
        end else begin
            on[2] = link & ~s.blink_ph;
        end
        on[1] = speed_100;
        case (mode)
            2'h1: on[0] = activity;
            2'h2: on[0] = collision;
            2'h3: on[0] = full_duplex;
            default: on[0] = 1'b0;
        endcase
        n.led = on ^ pol;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else if (clk_en) begin
            s <= n;
        end
    end

    assign link_indicator = s.led[2];
    assign speed_indicator = s.led[1];
    assign activity_collision_indicator = s.led[0];

endmodule

/* File: dv/pnc_chk.sv */
// Purpose: Port-level checks for pnc_top
// Assumes: Straps steady after reset, AN strap enabled
// Notes: Bound to every pnc_top instance

module pnc_chk
    import pnc_pkg::*;
#(
    parameter int unsigned BREAK_CYCLES = 20
) (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic clk_en, // Enable
    input wire pnc_mgmt_req_type mgmt_req, // Mgmt access
    input wire logic mgmt_rvalid, // Read valid
    input wire pnc_strap_type straps, // Straps
    input wire logic packet_ok, // Packet seen
    input wire logic tx_en_gated, // Gated enable
    input wire logic mii_out_oe_b, // MII enable
    input wire logic media_data_en, // Data allowed
    input wire logic media_pulse_en, // Pulses allowed
    input wire logic flp_send, // Bursts
    input wire logic crossover, // Swap
    input wire logic link_up, // Link
    input wire logic speed_100, // Speed
    input wire logic speed_indicator // Speed pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] low_ff;
    logic up_ff;
    logic wr_ok;

    // First edge latches straps, so requests count from the second
    assign wr_ok = up_ff && clk_en && mgmt_req.wr;

    // ==========================================
    // Helpers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_ff <= '0;
            up_ff <= 1'b0;
        end else if (clk_en) begin
            // Strap cycle is not a break, so it must not count as one
            low_ff <= (media_pulse_en || !up_ff) ? '0 : low_ff + 32'h1;
            up_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ==========================================
    // Assertions
    restart_break_a: assert property (wr_ok && mgmt_req.addr == REG_BMC
        && mgmt_req.wdata[12] && mgmt_req.wdata[9]
        |=> !media_pulse_en && !flp_send) else $error("restart ignored");
    break_len_a: assert property ($rose(media_pulse_en) && low_ff != 0
        |-> low_ff == BREAK_CYCLES) else $error("break length wrong");
    break_burst_a: assert property ($rose(media_pulse_en)
        && low_ff != 0 |-> flp_send) else $error("no bursts after break");
    xover_force_a: assert property (wr_ok && mgmt_req.addr == REG_PCTL
        && mgmt_req.wdata[14] |-> ##[1:2] crossover)
        else $error("force crossover ignored");
    isolate_gate_a: assert property (mii_out_oe_b
        |-> !tx_en_gated && !media_data_en) else $error("isolate leaks");
    read_answer_a: assert property (up_ff && clk_en && mgmt_req.rd
        && !mgmt_req.wr |=> mgmt_rvalid) else $error("read unanswered");
    speed_led_a: assert property (up_ff && $past(up_ff)
        && $past(clk_en) |-> speed_indicator == ($past(speed_100)
        ^ straps.an1)) else $error("speed indicator wrong");
    link_packet_a: assert property (up_ff && clk_en && packet_ok
        |=> link_up) else $error("packet gave no link");
endmodule

bind pnc_top pnc_chk #(.BREAK_CYCLES(BREAK_CYCLES)) chk_u (.ref_clk,
    .rst_b, .clk_en, .mgmt_req, .mgmt_rvalid, .straps, .packet_ok,
    .tx_en_gated, .mii_out_oe_b, .media_data_en, .media_pulse_en,
    .flp_send, .crossover, .link_up, .speed_100, .speed_indicator);

/* File: dv/pnc_partner.sv */
// Purpose: Line-side forced link partner
// Assumes: Bench changes mode between tests
// Notes: Never negotiates, so page strobe stays low

module pnc_partner (
    input wire logic ref_clk, // Clock
    input wire logic [1:0] mode, // 1 100M, 2 10M, 3 both
    output logic signal_detect, // 100M signal
    output logic nlp_pulse, // Link pulse
    output logic packet_ok, // 10M packet
    output logic flp_burst_seen, // Bursts
    output logic flp_page_valid, // Page strobe
    output logic [15:0] flp_page // Page bits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt = 2'h0;

    initial begin
        {signal_detect, nlp_pulse, packet_ok} = 3'h0;
        {flp_burst_seen, flp_page_valid} = 2'h0;
        flp_page = 16'h0;
    end

    always @(posedge ref_clk) begin
        #1;
        cnt = cnt + 2'h1;
        signal_detect = mode[0];
        nlp_pulse = mode[1] && cnt == 2'h0;
        packet_ok = mode == 2'h2 && cnt == 2'h2;
        // Page not valid, so never hold a stale word
        flp_page = ~flp_page;
    end
endmodule

/* File: dv/pnc_top_test.sv */
// Purpose: Self-checking bench for pnc_top
// Assumes: Shortened timers, strapped station address zero
// Notes: Reads are compared with an integer register model

module pnc_top_test
    import pnc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic tx_en_in = 1'b0, tx_active = 1'b0, rx_active = 1'b0, col_in = 1'b0;
    logic signal_detect, nlp_pulse, packet_ok, flp_burst_seen;
    logic flp_page_valid, mgmt_rvalid, mii_out_oe_b, media_pulse_en;
    logic flp_send, crossover;
    logic [15:0] flp_page, mgmt_rdata;
    logic [1:0] pmode = 2'h0;
    pnc_mgmt_req_type mgmt_req = '0;
    pnc_strap_type straps;
    int error_cnt = 0, tests_run = 0;
    int mdl[int];

    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) #1 {tx_en_in, tx_active, rx_active, col_in} = 4'($urandom);

    pnc_partner part_u (.ref_clk, .mode(pmode), .signal_detect, .nlp_pulse,
        .packet_ok, .flp_burst_seen, .flp_page_valid, .flp_page);
    pnc_top #(.BREAK_CYCLES(20), .AN_CYCLES(200), .LOSS_CYCLES(30),
        .XOVER_CYCLES(8), .BLINK_CYCLES(4)) dut_u (.ref_clk, .rst_b,
        .clk_en, .mgmt_req, .mgmt_rdata, .mgmt_rvalid, .straps,
        .signal_detect, .nlp_pulse, .packet_ok, .flp_burst_seen,
        .flp_page_valid, .flp_page, .tx_en_in, .tx_active, .rx_active,
        .col_in, .tx_en_gated(), .mii_out_oe_b, .media_data_en(),
        .media_pulse_en, .flp_send, .crossover, .link_up(), .speed_100(),
        .full_duplex(), .link_indicator(), .speed_indicator(),
        .activity_collision_indicator());

    // ==========================================
    // Tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_for(ref logic s, input logic v);
        for (int i = 0; i < 600 && s !== v; i++) tick(1);
        if (s !== v) begin
            chk("wait", {15'h0, s}, {15'h0, v});
            close_out();
        end
    endtask

    // Read lands at the taking edge, one cycle after the request is driven
    task automatic rd(logic [4:0] a, logic [15:0] m, string nm);
        mgmt_req.rd = 1'b1;
        mgmt_req.addr = a;
        tick(1);
        chk("rvalid", {15'h0, mgmt_rvalid}, 16'h1);
        chk(nm, mgmt_rdata & m, 16'(mdl[a]) & m);
        mgmt_req.rd = 1'b0;
        tick(1);
    endtask

    task automatic wr(logic [4:0] a, logic [15:0] v);
        mgmt_req.wr = 1'b1;
        mgmt_req.addr = a;
        mgmt_req.wdata = v;
        tick(1);
        mgmt_req.wr = 1'b0;
        tick(1);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        logic [4:0] a;
        void'($urandom(7161));
        straps = pnc_strap_type'($urandom);
        straps.station_address_strap = 5'h00;
        straps.negotiation_strap = 1'b1;
        repeat (12) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        tick(2);
        chk("isolate", {15'h0, mii_out_oe_b}, 16'h1);
        mdl[REG_PCTL] = 0;
        rd(REG_PCTL, 16'h001f, "address");
        $display("test straps done");
        pmode = 2'h1;
        wait_for(flp_send, 1'b1);
        wait_for(flp_send, 1'b0);
        mdl[REG_LPA] = 16'h0081;
        mdl[REG_BMS] = 16'h0020;
        mdl[REG_EXP] = 16'h0010;
        rd(REG_LPA, 16'hffff, "ability 100");
        rd(REG_BMS, 16'h0020, "complete");
        rd(REG_EXP, 16'h0001, "partner able");
        $display("test detect done");
        // Both links must be up before detection starts
        pmode = 2'h3;
        tick(20);
        wr(REG_BMC, 16'h1200);
        wait_for(flp_send, 1'b1);
        tick(40);
        rd(REG_EXP, 16'h0010, "fault");
        $display("test fault done");
        pmode = 2'h2;
        wait_for(flp_send, 1'b0);
        mdl[REG_LPA] = 16'h0021;
        rd(REG_LPA, 16'hffff, "ability 10");
        pmode = 2'h0;
        wait_for(flp_send, 1'b1);
        chk("no break", {15'h0, media_pulse_en}, 16'h1);
        wr(REG_PCTL, 16'h4000);
        chk("crossover", {15'h0, crossover}, 16'h1);
        mdl[REG_PCTL] = 16'h4000;
        rd(REG_PCTL, 16'hc07f, "control");
        repeat (4) begin
            a = 5'h07 + 5'($urandom_range(17));
            mdl[a] = 0;
            rd(a, 16'hffff, "unmapped");
        end
        $display("test loss done");
        wr(REG_BMC, 16'h0000);
        wr(REG_BMC, 16'h1000);
        chk("rearm", {15'h0, media_pulse_en}, 16'h0);
        $display("test rearm done");
        close_out();
    end
endmodule
